/* rtl/fdsp_pkg.sv */
// Shared constants and types for the full-duplex serial port with baud select.
`default_nettype none
package fdsp_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] FDSP_OFS_BUF = 8'h00;
  localparam logic [7:0] FDSP_OFS_SCTL = 8'h04;
  localparam logic [7:0] FDSP_OFS_PCTL = 8'h08;
  localparam logic [7:0] FDSP_OFS_T2CTL = 8'h0C;
  localparam logic [7:0] FDSP_OFS_RLDL = 8'h10;
  localparam logic [7:0] FDSP_OFS_RLDH = 8'h14;
  localparam logic [7:0] FDSP_OFS_T1 = 8'h18;
  localparam logic [7:0] FDSP_OFS_T2CNT = 8'h1C;
  // Field positions of serial_control.
  localparam int FDSP_SC_M0 = 7;
  localparam int FDSP_SC_M1 = 6;
  localparam int FDSP_SC_MPE = 5;
  localparam int FDSP_SC_REN = 4;
  localparam int FDSP_SC_TB8 = 3;
  localparam int FDSP_SC_RB8 = 2;
  localparam int FDSP_SC_TI = 1;
  localparam int FDSP_SC_RI = 0;
  // Field positions of power_control.
  localparam int FDSP_PC_DBL = 7;
  localparam int FDSP_PC_SIX = 0;
  // Field positions of timer2_control.
  localparam int FDSP_T2_TF = 7;
  localparam int FDSP_T2_EXF = 6;
  localparam int FDSP_T2_RCLK = 5;
  localparam int FDSP_T2_TX_CLOCK_SELECT = 4;
  localparam int FDSP_T2_EXEN = 3;
  localparam int FDSP_T2_RUN = 2;
  localparam int FDSP_T2_CT = 1;
  localparam int FDSP_T2_CAP = 0;
  // Timer 1 run bit inside the timer1_reload_byte register.
  localparam int FDSP_T1_RUN = 8;
  // Reset values.
  localparam logic [7:0] FDSP_RST_BYTE = 8'h00;
  localparam logic [15:0] FDSP_RST_WORD = 16'h0000;
  // Machine cycle lengths and sampling points.
  localparam logic [3:0] FDSP_MC12_LAST = 4'hB;
  localparam logic [3:0] FDSP_MC6_LAST = 4'h5;
  localparam logic [3:0] FDSP_MC12_HALF = 4'h6;
  localparam logic [3:0] FDSP_MC6_HALF = 4'h3;
  // Frame lengths and receive sample points in sixteenths of a bit.
  localparam logic [3:0] FDSP_BITS_M1 = 4'hA;
  localparam logic [3:0] FDSP_BITS_M23 = 4'hB;
  localparam logic [3:0] FDSP_BITS_M0 = 4'h8;
  localparam logic [3:0] FDSP_RX_LAST_IDX = 4'h9;
  localparam logic [3:0] FDSP_SMP_A = 4'h7;
  localparam logic [3:0] FDSP_SMP_C = 4'h9;
  localparam logic [3:0] FDSP_DIV16_LAST = 4'hF;
  // AXI responses.
  localparam logic [1:0] FDSP_RESP_OKAY = 2'b00;
  localparam logic [1:0] FDSP_RESP_SLVERR = 2'b10;

  // Serial port modes.
  typedef enum logic [1:0]
  {
    FDSP_MODE_SHIFT = 2'b00,
    FDSP_MODE_UART8 = 2'b01,
    FDSP_MODE_FIXED9 = 2'b10,
    FDSP_MODE_VAR9 = 2'b11
  } fdsp_mode_e;

  // Complete state of the port.
  typedef struct packed {
    logic aw_v;
    logic [7:0] aw_addr;
    logic w_v;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bv;
    logic [1:0] bresp;
    logic rv;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] sctl;
    logic [7:0] rxbuf;
    logic dbl;
    logic six;
    logic [7:0] timer2_control;
    logic [15:0] rcap;
    logic [15:0] t2cnt;
    logic [7:0] t1rld;
    logic t1run;
    logic [7:0] t1cnt;
    logic t1pre;
    logic [3:0] mc;
    logic [1:0] m2div;
    logic rx_s1;
    logic rx_s2;
    logic cp_s1;
    logic cp_s2;
    logic cp_d;
    logic tg_s1;
    logic tg_s2;
    logic tg_d;
    logic rxd_d;
    logic [3:0] txc16;
    logic tx_busy;
    logic tx_pend;
    logic [10:0] tx_sr;
    logic [3:0] tx_cnt;
    logic txd;
    logic rxd_out;
    logic rxd_oe_b;
    logic [3:0] rxc16;
    logic rx_busy;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sr;
    logic [2:0] rx_smp;
  } fdsp_state_s;
endpackage
`default_nettype wire

/* rtl/fdsp_top.sv */
// Serial port with four modes, two baud timers and an AXI4-Lite slave.
`default_nettype none
module fdsp_top
  import fdsp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // AXI4-Lite write address and data.
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  // AXI4-Lite write response.
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  // AXI4-Lite read.
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  // Serial pins.
  input wire logic RXD_I,
  output logic RXD_O,
  output logic RXD_OE_B_O,
  output logic TXD_O,
  // Timer 2 pins.
  input wire logic T2_COUNT_I,
  input wire logic T2_TRIGGER_I
);

  ////////////////////////////////////////////////////////////////////////////
  fdsp_state_s st_reg;
  fdsp_state_s st_next;
  fdsp_mode_e mode;
  logic mc_tick;
  logic [3:0] mc_last;
  logic [3:0] mc_half;
  logic t1_ovf;
  logic t1_16x;
  logic baud_mode;
  logic t2_inc;
  logic t2_ovf;
  logic trig_fall;
  logic [1:0] m2_mask;
  logic m2_tick;
  logic tx16;
  logic rx16;
  logic tx_roll;
  logic wr_go;
  logic [7:0] wa;
  logic [7:0] ra;
  logic maj;
  logic async_m;
  logic [31:0] rd_val;
  logic rd_err;
  logic wr_err;

  // Handshake outputs are simple functions of the held state.
  assign S_AXI_AWREADY_O = !st_reg.aw_v && !st_reg.bv;
  assign S_AXI_WREADY_O = !st_reg.w_v && !st_reg.bv;
  assign S_AXI_BVALID_O = st_reg.bv;
  assign S_AXI_BRESP_O = st_reg.bresp;
  assign S_AXI_ARREADY_O = !st_reg.rv;
  assign S_AXI_RVALID_O = st_reg.rv;
  assign S_AXI_RDATA_O = st_reg.rdata;
  assign S_AXI_RRESP_O = st_reg.rresp;
  assign RXD_O = st_reg.rxd_out;
  assign RXD_OE_B_O = st_reg.rxd_oe_b;
  assign TXD_O = st_reg.txd;

  // Timing strobes derived from the current state.
  assign mode = fdsp_mode_e'(st_reg.sctl[FDSP_SC_M0:FDSP_SC_M1]);
  assign async_m = (mode != FDSP_MODE_SHIFT);
  assign mc_last = st_reg.six ? FDSP_MC6_LAST : FDSP_MC12_LAST;
  assign mc_half = st_reg.six ? FDSP_MC6_HALF : FDSP_MC12_HALF;
  assign mc_tick = (st_reg.mc == mc_last);
  // Timer 1 counts machine cycles, so its rate doubles in 6-clock mode.
  assign t1_ovf = st_reg.t1run && mc_tick && (st_reg.t1cnt == 8'hFF);
  // Dividing the overflow by two unless doubled gives n of 32 or 16.
  assign t1_16x = t1_ovf && (st_reg.dbl || st_reg.t1pre);
  assign baud_mode = st_reg.timer2_control[FDSP_T2_RCLK] || st_reg.timer2_control[FDSP_T2_TX_CLOCK_SELECT];
  assign trig_fall = st_reg.tg_d && !st_reg.tg_s2;

  // Timer 2 tick source; baud mode counts per clock or every second clock.
  always_comb
  begin
    if (!st_reg.timer2_control[FDSP_T2_RUN])
      t2_inc = 1'b0;
    else if (st_reg.timer2_control[FDSP_T2_CT])
      t2_inc = st_reg.cp_d && !st_reg.cp_s2;
    else if (baud_mode)
      t2_inc = st_reg.six || st_reg.m2div[0];
    else
      t2_inc = mc_tick;
  end
  assign t2_ovf = t2_inc && (st_reg.t2cnt == 16'hFFFF);

  // Mode 2 sample rate: every 4, 2 or 1 clocks from fosc/64 down to fosc/16.
  always_comb
  begin
    case ({st_reg.six, st_reg.dbl})
      2'b00: m2_mask = 2'b11;
      2'b11: m2_mask = 2'b00;
      default: m2_mask = 2'b01;
    endcase
  end
  assign m2_tick = ((st_reg.m2div & m2_mask) == m2_mask);

  // Each direction picks its own sixteen-times bit clock.
  always_comb
  begin
    if (mode == FDSP_MODE_FIXED9)
    begin
      tx16 = m2_tick;
      rx16 = m2_tick;
    end
    else
    begin
      // Timer 2 overflow is already sixteen times the bit rate.
      tx16 = st_reg.timer2_control[FDSP_T2_TX_CLOCK_SELECT] ? t2_ovf : t1_16x;
      rx16 = st_reg.timer2_control[FDSP_T2_RCLK] ? t2_ovf : t1_16x;
    end
  end
  assign tx_roll = tx16 && (st_reg.txc16 == FDSP_DIV16_LAST);
  assign maj = (st_reg.rx_smp[0] & st_reg.rx_smp[1]) |
               (st_reg.rx_smp[0] & st_reg.rx_smp[2]) |
               (st_reg.rx_smp[1] & st_reg.rx_smp[2]);

  // Register read mux; unmapped addresses answer with an error and zero.
  assign ra = 8'(S_AXI_ARADDR_I);
  assign wa = st_reg.aw_addr;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (ra)
      FDSP_OFS_BUF: rd_val[7:0] = st_reg.rxbuf;
      FDSP_OFS_SCTL: rd_val[7:0] = st_reg.sctl;
      FDSP_OFS_PCTL:
      begin
        rd_val[FDSP_PC_DBL] = st_reg.dbl;
        rd_val[FDSP_PC_SIX] = st_reg.six;
      end
      FDSP_OFS_T2CTL: rd_val[7:0] = st_reg.timer2_control;
      FDSP_OFS_RLDL: rd_val[7:0] = st_reg.rcap[7:0];
      FDSP_OFS_RLDH: rd_val[7:0] = st_reg.rcap[15:8];
      FDSP_OFS_T1: rd_val[8:0] = {st_reg.t1run, st_reg.t1rld};
      FDSP_OFS_T2CNT: rd_val[15:0] = st_reg.t2cnt;
      default: rd_err = 1'b1;
    endcase
  end
  assign wr_go = st_reg.aw_v && st_reg.w_v && !st_reg.bv;
  always_comb
  begin
    case (wa)
      FDSP_OFS_BUF, FDSP_OFS_SCTL, FDSP_OFS_PCTL, FDSP_OFS_T2CTL,
      FDSP_OFS_RLDL, FDSP_OFS_RLDH, FDSP_OFS_T1, FDSP_OFS_T2CNT:
        wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole port.
  always_comb
  begin
    st_next = st_reg;
    // Bus channel capture.
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
    begin
      st_next.aw_v = 1'b1;
      st_next.aw_addr = 8'(S_AXI_AWADDR_I);
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O)
    begin
      st_next.w_v = 1'b1;
      st_next.wdata = S_AXI_WDATA_I;
      st_next.wstrb = S_AXI_WSTRB_I;
    end
    if (st_reg.bv && S_AXI_BREADY_I)
      st_next.bv = 1'b0;
    if (st_reg.rv && S_AXI_RREADY_I)
      st_next.rv = 1'b0;
    if (S_AXI_ARVALID_I && !st_reg.rv)
    begin
      st_next.rv = 1'b1;
      st_next.rdata = rd_val;
      st_next.rresp = rd_err ? FDSP_RESP_SLVERR : FDSP_RESP_OKAY;
    end

    // Input synchronisers and free-running dividers.
    st_next.rx_s1 = RXD_I;
    st_next.rx_s2 = st_reg.rx_s1;
    st_next.cp_s1 = T2_COUNT_I;
    st_next.cp_s2 = st_reg.cp_s1;
    st_next.cp_d = st_reg.cp_s2;
    st_next.tg_s1 = T2_TRIGGER_I;
    st_next.tg_s2 = st_reg.tg_s1;
    st_next.tg_d = st_reg.tg_s2;
    st_next.mc = mc_tick ? 4'h0 : st_reg.mc + 4'h1;
    st_next.m2div = st_reg.m2div + 2'b01;

    // Timer 1 in 8-bit auto-reload.
    if (st_reg.t1run && mc_tick)
      st_next.t1cnt = t1_ovf ? st_reg.t1rld : st_reg.t1cnt + 8'h01;
    if (t1_ovf)
      st_next.t1pre = !st_reg.t1pre;

    // Timer 2 count, reload, capture and flags.
    if (t2_inc)
      st_next.t2cnt = st_reg.t2cnt + 16'h0001;
    if (t2_ovf)
    begin
      if (baud_mode || !st_reg.timer2_control[FDSP_T2_CAP])
        st_next.t2cnt = st_reg.rcap;
      if (!baud_mode)
        st_next.timer2_control[FDSP_T2_TF] = 1'b1;
    end
    if (trig_fall && st_reg.timer2_control[FDSP_T2_EXEN])
    begin
      st_next.timer2_control[FDSP_T2_EXF] = 1'b1;
      // In baud mode the trigger edge flags only, it never reloads.
      if (!baud_mode && st_reg.timer2_control[FDSP_T2_CAP])
        st_next.rcap = st_reg.t2cnt;
      else if (!baud_mode)
        st_next.t2cnt = st_reg.rcap;
    end

    // Register writes; hardware flag sets below take precedence.
    if (wr_go)
    begin
      st_next.aw_v = 1'b0;
      st_next.w_v = 1'b0;
      st_next.bv = 1'b1;
      st_next.bresp = wr_err ? FDSP_RESP_SLVERR : FDSP_RESP_OKAY;
      if (st_reg.wstrb[0])
      begin
        case (wa)
          FDSP_OFS_SCTL: st_next.sctl = st_reg.wdata[7:0];
          FDSP_OFS_PCTL:
          begin
            st_next.dbl = st_reg.wdata[FDSP_PC_DBL];
            st_next.six = st_reg.wdata[FDSP_PC_SIX];
          end
          FDSP_OFS_T2CTL: st_next.timer2_control = st_reg.wdata[7:0];
          FDSP_OFS_RLDL: st_next.rcap[7:0] = st_reg.wdata[7:0];
          FDSP_OFS_RLDH: st_next.rcap[15:8] = st_reg.wdata[7:0];
          FDSP_OFS_T1: st_next.t1rld = st_reg.wdata[7:0];
          default: st_next.t2cnt = st_next.t2cnt;
        endcase
      end
      if (st_reg.wstrb[1] && (wa == FDSP_OFS_T1))
        st_next.t1run = st_reg.wdata[FDSP_T1_RUN];
      // A buffer write loads the transmit shifter and requests a frame.
      if (st_reg.wstrb[0] && (wa == FDSP_OFS_BUF))
      begin
        st_next.tx_pend = 1'b1;
        st_next.tx_busy = 1'b0;
        if (mode == FDSP_MODE_UART8)
        begin
          st_next.tx_sr = {2'b11, st_reg.wdata[7:0], 1'b0};
          st_next.tx_cnt = FDSP_BITS_M1;
        end
        else if (async_m)
        begin
          st_next.tx_sr = {1'b1, st_reg.sctl[FDSP_SC_TB8],
                           st_reg.wdata[7:0], 1'b0};
          st_next.tx_cnt = FDSP_BITS_M23;
        end
        else
        begin
          st_next.tx_sr = {3'b000, st_reg.wdata[7:0]};
          st_next.tx_cnt = FDSP_BITS_M0;
        end
      end
    end

    // Transmit side; it never waits on the receiver.
    if (tx16)
      st_next.txc16 = st_reg.txc16 + 4'h1;
    if (!async_m && mc_tick)
    begin
      // Mode 0 starts at the first machine-cycle end after the write.
      if (st_reg.tx_pend)
      begin
        st_next.tx_pend = 1'b0;
        st_next.tx_busy = 1'b1;
      end
      else if (st_reg.tx_busy)
      begin
        st_next.tx_sr = {1'b0, st_reg.tx_sr[10:1]};
        st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
        if (st_reg.tx_cnt == 4'h1)
        begin
          st_next.tx_busy = 1'b0;
          st_next.sctl[FDSP_SC_TI] = 1'b1;
        end
      end
    end
    else if (async_m && tx_roll)
    begin
      // Bit times follow the divide-by-16 counter, not the write.
      if (st_reg.tx_pend)
      begin
        st_next.tx_pend = 1'b0;
        st_next.tx_busy = 1'b1;
      end
      else if (st_reg.tx_busy)
      begin
        st_next.tx_sr = {1'b1, st_reg.tx_sr[10:1]};
        st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
        if (st_reg.tx_cnt == 4'h1)
        begin
          st_next.tx_busy = 1'b0;
          st_next.sctl[FDSP_SC_TI] = 1'b1;
        end
      end
    end

    // Receive side, mode 0: shift clock on the transmit pin.
    if (!async_m)
    begin
      if (!st_reg.rx_busy && !st_reg.tx_busy && !st_reg.tx_pend &&
          st_reg.sctl[FDSP_SC_REN] && !st_reg.sctl[FDSP_SC_RI] && mc_tick)
      begin
        st_next.rx_busy = 1'b1;
        st_next.rx_cnt = FDSP_BITS_M0;
      end
      else if (st_reg.rx_busy && mc_tick)
      begin
        st_next.rx_sr = {st_reg.rx_s2, st_reg.rx_sr[7:1]};
        st_next.rx_cnt = st_reg.rx_cnt - 4'h1;
        if (st_reg.rx_cnt == 4'h1)
        begin
          // The multiprocessor bit plays no part in this mode.
          st_next.rx_busy = 1'b0;
          st_next.rxbuf = {st_reg.rx_s2, st_reg.rx_sr[7:1]};
          st_next.sctl[FDSP_SC_RI] = 1'b1;
        end
      end
    end
    else if (rx16)
    begin
      // Asynchronous receive at sixteen samples per bit.
      st_next.rxd_d = st_reg.rx_s2;
      st_next.rxc16 = st_reg.rxc16 + 4'h1;
      if (!st_reg.rx_busy)
      begin
        if (st_reg.sctl[FDSP_SC_REN] && st_reg.rxd_d && !st_reg.rx_s2)
        begin
          st_next.rx_busy = 1'b1;
          st_next.rxc16 = 4'h0;
          st_next.rx_cnt = 4'h0;
        end
      end
      else
      begin
        if (st_reg.rxc16 >= FDSP_SMP_A && st_reg.rxc16 <= FDSP_SMP_C)
          st_next.rx_smp = {st_reg.rx_smp[1:0], st_reg.rx_s2};
        if (st_reg.rxc16 == FDSP_SMP_C + 4'h1)
        begin
          st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
          if (st_reg.rx_cnt == 4'h0 && maj)
            st_next.rx_busy = 1'b0; // False start bit.
          else if (st_reg.rx_cnt != 4'h0 &&
                   st_reg.rx_cnt != FDSP_RX_LAST_IDX)
            st_next.rx_sr = {maj, st_reg.rx_sr[7:1]};
          else if (st_reg.rx_cnt == FDSP_RX_LAST_IDX)
          begin
            // Stop bit in mode 1, ninth bit in modes 2 and 3.
            st_next.rx_busy = 1'b0;
            if (!st_reg.sctl[FDSP_SC_RI] &&
                (!st_reg.sctl[FDSP_SC_MPE] || maj))
            begin
              // An unread byte blocks the new one, which is lost.
              st_next.rxbuf = st_reg.rx_sr;
              st_next.sctl[FDSP_SC_RB8] = maj;
              st_next.sctl[FDSP_SC_RI] = 1'b1;
            end
          end
        end
      end
    end

    // Pin drive: mode 0 owns the receive pin while shifting out.
    st_next.rxd_oe_b = async_m || !st_next.tx_busy;
    st_next.rxd_out = st_next.tx_busy ? st_next.tx_sr[0] : 1'b1;
    if (async_m)
      st_next.txd = st_next.tx_busy ? st_next.tx_sr[0] : 1'b1;
    else if (st_next.tx_busy || st_next.rx_busy)
      st_next.txd = (st_next.mc >= mc_half);
    else
      st_next.txd = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with asynchronous reset to constants.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      st_reg <= '0;
      st_reg.sctl <= FDSP_RST_BYTE;
      st_reg.timer2_control <= FDSP_RST_BYTE;
      st_reg.rcap <= FDSP_RST_WORD;
      st_reg.rx_s1 <= 1'b1;
      st_reg.rx_s2 <= 1'b1;
      st_reg.cp_s1 <= 1'b1;
      st_reg.cp_s2 <= 1'b1;
      st_reg.cp_d <= 1'b1;
      st_reg.tg_s1 <= 1'b1;
      st_reg.tg_s2 <= 1'b1;
      st_reg.tg_d <= 1'b1;
      st_reg.rxd_d <= 1'b1;
      st_reg.txd <= 1'b1;
      st_reg.rxd_out <= 1'b1;
      st_reg.rxd_oe_b <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire

/* tb/fdsp_checker.sv */
// Bus and link checks on the serial port top ports.
`default_nettype none
module fdsp_checker
  import fdsp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // Register bus.
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  // Serial pin.
  input wire logic TXD_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  //////////////////////////////////////////////////////////////////////////
  // Answers stand until taken, so a slow master never loses a result.
  a_bvalid_hold: assert property (
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("rdata moved");
  a_read_answer: assert property (
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("no read answer");
  a_write_block: assert property (
    S_AXI_BVALID_O |-> !S_AXI_AWREADY_O) else $error("aw taken early");
  a_read_block: assert property (
    S_AXI_RVALID_O |-> !S_AXI_ARREADY_O) else $error("ar taken early");
  a_unmapped_read: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O &&
    S_AXI_ARADDR_I > 8'h1F |=> S_AXI_RRESP_O == FDSP_RESP_SLVERR &&
    S_AXI_RDATA_O == 32'h0) else $error("unmapped read");
  a_upper_zero: assert property (
    S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0)
    else $error("upper bits set");
  // No low bit or low shift-clock phase on TXD_O is shorter than three clocks.
  a_low_min: assert property (
    $fell(TXD_O) |-> !TXD_O [*3]) else $error("short low on txd");
  c_frame: cover property ($rose(TXD_O));
  c_slverr: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == FDSP_RESP_SLVERR);
  c_write: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
endmodule
`default_nettype wire

/* tb/fdsp_peer.sv */
// Remote serial port model: sends frames and decodes received ones.
`default_nettype none
module fdsp_peer
#(
  parameter int BIT_CLKS = 64
)
(
  // Clock and link.
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  // Last decoded frame, stop bit on top, and frame count.
  output logic [9:0] got_o,
  output int got_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////
  // The line idles high between frames.
  initial
  begin
    rxd_o = 1'b1;
    got_o = 10'h000;
    got_cnt_o = 0;
  end
  // Sample each bit at its middle, counted from the start edge.
  always
  begin
    @(negedge txd_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk_i);
      got_o[i] <= txd_i;
    end
    got_cnt_o <= got_cnt_o + 1;
  end
  // Start, eight data LSB first, ninth, stop; call just after an edge.
  task automatic send(input logic [8:0] w);
    logic [10:0] f;
    f = {1'b1, w, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd_o <= f[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench: register access and mode 2 traffic both ways.
`default_nettype none
module tb_top
  import fdsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = 64; // Mode 2, 12-clock, no doubling.
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic trig = 1'b1;
  logic aw_rdy, w_rdy, bv, ar_rdy, rv, txd, rx_out, rx_oe_b, peer_rxd;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] got;
  int got_cnt;
  int error_cnt = 0;
  int checked = 0;
  //////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  fdsp_top fdsp_top_inst
  (
    .CORE_CLK_I(clk), .RST_B_I(rst_b),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_AWADDR_I(awa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(w_rdy), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(ar_rdy),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .RXD_I(rx_oe_b ? peer_rxd : rx_out), .RXD_O(rx_out),
    .RXD_OE_B_O(rx_oe_b), .TXD_O(txd),
    .T2_COUNT_I(1'b1), .T2_TRIGGER_I(trig)
  );
  fdsp_peer #(.BIT_CLKS(BITC)) fdsp_peer_inst
  (
    .clk_i(clk), .txd_i(txd), .rxd_o(peer_rxd),
    .got_o(got), .got_cnt_o(got_cnt)
  );
  task automatic cmp(input string what, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  // Address and data offered together; each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    // Let an edge pass so bready is never assigned twice in one step.
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (!aw_done && aw_rdy)
      begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (!w_done && w_rdy)
      begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end
    while (!(aw_done && w_done));
    do @(posedge clk); while (!bv);
    bready <= 1'b0;
    cmp("bresp", 32'(FDSP_RESP_OKAY), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rready <= 1'b1;
    do @(posedge clk); while (!ar_rdy);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp(what, e, d);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A hang is cut short well beyond the few frames sent here.
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(FDSP_OFS_SCTL, 32'h0, "sctl reset");
    rdc(FDSP_OFS_PCTL, 32'h0, "pctl reset");
    rd(8'h20, d, r);
    cmp("unmapped", 32'(FDSP_RESP_SLVERR), 32'(r));
    wr(FDSP_OFS_SCTL, 32'h98); // Mode 2, receive on, ninth bit set.
    wr(FDSP_OFS_BUF, 32'hA5);
    fdsp_peer_inst.send(9'h13C);
    while (got_cnt < 1) @(posedge clk);
    repeat (BITC) @(posedge clk);
    cmp("tx frame", 32'h3A5, 32'(got));
    rdc(FDSP_OFS_SCTL, 32'h9F, "flags");
    rdc(FDSP_OFS_BUF, 32'h3C, "rx byte");
    wr(FDSP_OFS_SCTL, 32'hB0); // Multiprocessor filter on, flags cleared.
    fdsp_peer_inst.send(9'h055);
    rdc(FDSP_OFS_SCTL, 32'hB0, "data dropped");
    fdsp_peer_inst.send(9'h1C3);
    rdc(FDSP_OFS_SCTL, 32'hB5, "addr taken");
    rdc(FDSP_OFS_BUF, 32'hC3, "addr byte");
    wr(FDSP_OFS_BUF, 32'h5A);
    while (got_cnt < 2) @(posedge clk);
    cmp("tx ninth 0", 32'h25A, 32'(got));
    // Timer 2 preset by a trigger reload, then used as the baud source.
    wr(FDSP_OFS_RLDL, 32'hFE);
    wr(FDSP_OFS_RLDH, 32'hFF);
    wr(FDSP_OFS_T2CTL, 32'h08);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    trig <= 1'b1;
    rdc(FDSP_OFS_T2CNT, 32'hFFFE, "trigger reload");
    wr(FDSP_OFS_T2CTL, 32'h34);
    wr(FDSP_OFS_SCTL, 32'hC8); // Mode 3, ninth bit set.
    wr(FDSP_OFS_BUF, 32'h96);
    while (got_cnt < 3) @(posedge clk);
    cmp("mode 3 frame", 32'h396, 32'(got));
    cmp("rxd released", 32'h1, 32'(rx_oe_b));
    tally_and_finish();
  end
endmodule
bind fdsp_top fdsp_checker #(.ADDR_W(ADDR_W)) fdsp_checker_inst
(
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .TXD_O(TXD_O)
);
`default_nettype wire
